/* File: common/cfb_pkg.sv */
/*
  constants, coil map and carrier types for the eight-channel counter and frequency bank.
  assumes a 25 MHz system clock and a protocol front end that turns coil frames into
  single-bit requests on the coil port.
*/
// Functional notes
// (R01) status bit: input xor mask per channel
// (R02) status bit: input level after filter stage
// (R03) overflow flag per counter, write one clears
// (R04) protocol bit: zero vendor ascii, one rtu
// (R05) read-write bit enables host watchdog
// (R06) format bit: zero hex, one float
// (R07) watchdog timeout flag, write one clears
// (R08) reset flag reads one first time only
// (R09) write one clears that counter to zero
// (R10) per counter battery retention enable bit
// (R11) per channel automatic frequency mode selection
// (R12) per channel high or low mode bit
// (R13) halt counting after overflow when enabled
// (R14) per channel filter enable or bypass
// (R15) per channel mask bit inverts input
// (R16) override at power-on forces fixed link settings
// (R17) protocol, baud, checksum change only in override
// (R18) watchdog expiry drives outputs to safe state
// (R19) reset flag set by resets, cleared after query
// (R20) indicator off on command, on after response
// (R21) low mode counts reference over one period
// (R22) high mode counts over eleven periods
// (R23) filter time microseconds, shared per channel group
// (R24) watchdog timeout 0..255 in tenth seconds
// (R25) writing zero to clear bits does nothing
// (R26) auto mode thresholds with hysteresis
package cfb_pkg;
  localparam int CFB_CH = 8;

  // coil addresses, printed numbering kept as the address on the coil port
  localparam logic [15:0] CFB_MASKED_IN = 16'h0021;
  localparam logic [15:0] CFB_FILT_IN = 16'h0029;
  localparam logic [15:0] CFB_OVF = 16'h0041;
  localparam logic [15:0] CFB_PROTO = 16'h0101;
  localparam logic [15:0] CFB_HWD_EN = 16'h0105;
  localparam logic [15:0] CFB_FMT = 16'h010D;
  localparam logic [15:0] CFB_HWD_FLAG = 16'h010E;
  localparam logic [15:0] CFB_RST_FLAG = 16'h0111;
  localparam logic [15:0] CFB_CLR = 16'h0201;
  localparam logic [15:0] CFB_RETAIN = 16'h0301;
  localparam logic [15:0] CFB_AUTO = 16'h0321;
  localparam logic [15:0] CFB_HIGH = 16'h0341;
  localparam logic [15:0] CFB_HALT = 16'h0361;
  localparam logic [15:0] CFB_FILT_EN = 16'h0381;
  localparam logic [15:0] CFB_INV = 16'h03A1;

  // reset values of the stored coils
  localparam logic [7:0] CFB_BANK_RST = 8'h00;
  localparam logic CFB_BIT_RST = 1'b0;

  // timing
  localparam int CFB_CLK_HZ = 25_000_000;
  localparam int CFB_US_PER_S = 1_000_000;
  localparam int CFB_US_CYCLES = CFB_CLK_HZ / CFB_US_PER_S;
  localparam logic [19:0] CFB_US_CYCLES_W = 20'(CFB_US_CYCLES);
  localparam int CFB_WD_STEP_MS = 100;
  localparam int CFB_WD_STEP_CYCLES = CFB_CLK_HZ / 1000 * CFB_WD_STEP_MS;

  // frequency measurement
  localparam logic [3:0] CFB_LO_PERIODS = 4'h1;
  localparam logic [3:0] CFB_HI_PERIODS = 4'hB;
  localparam int CFB_AUTO_UP_HZ = 10_000;
  localparam int CFB_AUTO_DN_HZ = 8_000;
  localparam logic [31:0] CFB_UP_LIMIT = 32'(CFB_CLK_HZ / CFB_AUTO_UP_HZ);
  localparam logic [31:0] CFB_DN_LIMIT = 32'(11 * (CFB_CLK_HZ / CFB_AUTO_DN_HZ));

  // link settings forced in override mode, and the strap capture wait
  localparam logic [7:0] CFB_OVR_ADDR = 8'h00;
  localparam int CFB_OVR_BAUD_BPS = 9600;
  localparam logic [1:0] CFB_START_WAIT = 2'h2;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic data;
  } cfb_coil_req_t;

  typedef struct packed {
    logic valid;
    logic hit;
    logic data;
  } cfb_coil_rsp_t;

  typedef enum logic [0:0] {CFB_SYNC_WAIT, CFB_TIMING} cfb_meas_t;
endpackage : cfb_pkg

/* File: verilog/cfb_counter_bank.sv */
/*
  eight-channel pulse counter, period-counting frequency meter and control coils.
  assumes a protocol front end on the same clock that issues coil requests, reports
  command and response events, and kicks the host watchdog on valid host traffic.
*/
`timescale 1ns/100ps
module cfb_counter_bank
  import cfb_pkg::*;
#(
  parameter int COUNT_W = 32,
  parameter int WD_STEP_CYCLES = CFB_WD_STEP_CYCLES
)(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clockEnable,
  input wire logic [CFB_CH-1:0] chanIn,
  input wire logic configOverridePin,
  input wire cfb_coil_req_t coilReq,
  output cfb_coil_rsp_t coilRsp,
  input wire logic [2:0][14:0] filterTimeUs,
  input wire logic [7:0] hostWdTimeout,
  input wire logic hostActivity,
  input wire logic moduleWdReset,
  input wire logic resetStatusQuery,
  input wire logic cmdReceived,
  input wire logic respSent,
  input wire logic linkCfgReq,
  output logic linkCfgAccept,
  output logic overrideMode,
  output logic protocolRtu,
  output logic floatFormat,
  output logic safeState,
  output logic activityLed,
  output logic resetFlag,
  output logic [CFB_CH-1:0] retainEnable,
  output logic [CFB_CH-1:0] highModeActive,
  output logic [CFB_CH-1:0] overflowFlag,
  output logic [CFB_CH-1:0][COUNT_W-1:0] countValue,
  output logic [CFB_CH-1:0][31:0] freqValue
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [7:0] chanHit(input logic [15:0] addr, input logic [15:0] base);
    logic [15:0] d;
    d = addr - base;
    chanHit = (d < 16'h0008) ? (8'h01 << d[2:0]) : 8'h00;
  endfunction : chanHit

  function automatic logic [7:0] bankWrite(input logic [7:0] old, input logic [7:0] hit,
                                           input logic data);
    bankWrite = (old & ~hit) | (hit & {8{data}});
  endfunction : bankWrite

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [CFB_CH-1:0] chanMeta, chanSync;
  logic ovrMeta, ovrSync;
  logic [1:0] startCnt;

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      chanMeta <= CFB_BANK_RST;
      chanSync <= CFB_BANK_RST;
    end
    else if (clockEnable)
    begin
      chanMeta <= chanIn;
      chanSync <= chanMeta;
    end
  end

  // strap synchroniser keeps sampling through reset, so it is settled when the strap is caught
  always_ff @(posedge clock)
  begin
    if (clockEnable)
    begin
      ovrMeta <= configOverridePin;
      ovrSync <= ovrMeta;
    end
  end

  // override is a power-on strap: caught once the synchroniser has settled after release
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      startCnt <= 2'h0;
      overrideMode <= 1'b0;
    end
    else if (clockEnable && startCnt != CFB_START_WAIT)
    begin
      startCnt <= startCnt + 2'h1;
      if (startCnt + 2'h1 == CFB_START_WAIT)
        overrideMode <= ovrSync; // [R16]
    end
  end

  // ****************************************************************
  // coil decode
  // ****************************************************************
  logic [7:0] ovfReg, retainReg, autoReg, highReg, haltReg, filtEnReg, invReg;
  logic protoSel, hwdEn, hwdFlag;
  logic [7:0] maskedIn, chanLevel;

  wire wrStb = coilReq.valid && coilReq.write;
  wire rdStb = coilReq.valid && !coilReq.write;
  wire wrOne = wrStb && coilReq.data;
  wire [7:0] hitMasked = chanHit(coilReq.addr, CFB_MASKED_IN);
  wire [7:0] hitFilt = chanHit(coilReq.addr, CFB_FILT_IN);
  wire [7:0] hitOvf = chanHit(coilReq.addr, CFB_OVF);
  wire [7:0] hitClr = chanHit(coilReq.addr, CFB_CLR);
  wire [7:0] hitRetain = chanHit(coilReq.addr, CFB_RETAIN);
  wire [7:0] hitAuto = chanHit(coilReq.addr, CFB_AUTO);
  wire [7:0] hitHigh = chanHit(coilReq.addr, CFB_HIGH);
  wire [7:0] hitHalt = chanHit(coilReq.addr, CFB_HALT);
  wire [7:0] hitFiltEn = chanHit(coilReq.addr, CFB_FILT_EN);
  wire [7:0] hitInv = chanHit(coilReq.addr, CFB_INV);
  wire isProto = coilReq.addr == CFB_PROTO;
  wire isHwdEn = coilReq.addr == CFB_HWD_EN;
  wire isFmt = coilReq.addr == CFB_FMT;
  wire isHwdFlag = coilReq.addr == CFB_HWD_FLAG;
  wire isRstFlag = coilReq.addr == CFB_RST_FLAG;
  wire [7:0] ovfClear = wrOne ? hitOvf : 8'h00; // [R03] [R25]
  wire [7:0] cntClear = wrOne ? hitClr : 8'h00; // [R09] [R25]
  wire protoWrite = wrStb && isProto;
  wire rstFlagRead = (rdStb && isRstFlag) || resetStatusQuery;
  wire anyHit = |{hitMasked, hitFilt, hitOvf, hitClr, hitRetain, hitAuto, hitHigh, hitHalt,
                  hitFiltEn, hitInv, isProto, isHwdEn, isFmt, isHwdFlag, isRstFlag};
  // write-only clear coils read back as zero
  wire rdBit = |(hitMasked & maskedIn) | |(hitFilt & chanLevel) | |(hitOvf & ovfReg) // [R01] [R02]
             | |(hitRetain & retainReg) | |(hitAuto & autoReg) | |(hitHigh & highReg)
             | |(hitHalt & haltReg) | |(hitFiltEn & filtEnReg) | |(hitInv & invReg)
             | (isProto & protoSel) | (isHwdEn & hwdEn) | (isFmt & floatFormat)
             | (isHwdFlag & hwdFlag) | (isRstFlag & resetFlag);

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      retainReg <= CFB_BANK_RST;
      autoReg <= CFB_BANK_RST;
      highReg <= CFB_BANK_RST;
      haltReg <= CFB_BANK_RST;
      filtEnReg <= CFB_BANK_RST;
      invReg <= CFB_BANK_RST;
      protoSel <= CFB_BIT_RST;
      hwdEn <= CFB_BIT_RST;
      floatFormat <= CFB_BIT_RST;
      coilRsp <= '0;
      linkCfgAccept <= 1'b0;
    end
    else if (clockEnable)
    begin
      if (wrStb)
      begin
        retainReg <= bankWrite(retainReg, hitRetain, coilReq.data); // [R10]
        autoReg <= bankWrite(autoReg, hitAuto, coilReq.data); // [R11]
        highReg <= bankWrite(highReg, hitHigh, coilReq.data); // [R12]
        haltReg <= bankWrite(haltReg, hitHalt, coilReq.data); // [R13]
        filtEnReg <= bankWrite(filtEnReg, hitFiltEn, coilReq.data); // [R14]
        invReg <= bankWrite(invReg, hitInv, coilReq.data); // [R15]
        if (isHwdEn)
          hwdEn <= coilReq.data; // [R05]
        if (isFmt)
          floatFormat <= coilReq.data; // [R06]
      end
      if (protoWrite && overrideMode)
        protoSel <= coilReq.data; // [R04] [R17]
      coilRsp.valid <= coilReq.valid;
      coilRsp.hit <= coilReq.valid && anyHit;
      coilRsp.data <= rdStb && rdBit;
      linkCfgAccept <= linkCfgReq && overrideMode; // [R17]
    end
  end

  // protocol output stays on the vendor protocol while override is active
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      protocolRtu <= 1'b0;
    else if (clockEnable)
      protocolRtu <= !overrideMode && protoSel; // [R04] [R16]
  end

  assign overflowFlag = ovfReg;
  assign retainEnable = retainReg;
  assign safeState = hwdFlag;

  // ****************************************************************
  // channels: mask, filter, counter, period meter
  // ****************************************************************
  assign maskedIn = chanSync ^ invReg; // [R01] [R15]

  genvar ch;
  generate
    for (ch = 0; ch < CFB_CH; ch++)
    begin : gChan
      localparam int GRP = (ch < 2) ? 0 : ((ch < 4) ? 1 : 2);
      logic filtState, prevLevel, effHigh;
      logic [19:0] filtCnt;
      cfb_meas_t measState;
      logic [31:0] refCnt;
      logic [3:0] perCnt;
      // one filter time per group; zero lets a change through on its first clock, with no delay
      wire [19:0] filtLimit = 20'(filterTimeUs[GRP]) * CFB_US_CYCLES_W; // [R23]
      wire filtDiff = maskedIn[ch] != filtState;
      wire filtDone = filtDiff && (filtCnt + 20'h1 >= filtLimit);
      wire rise = chanLevel[ch] && !prevLevel;
      wire cntFull = &countValue[ch];
      wire cntStop = haltReg[ch] && ovfReg[ch]; // [R13]
      wire [3:0] target = effHigh ? CFB_HI_PERIODS : CFB_LO_PERIODS; // [R21] [R22]
      wire periodEnd = rise && measState == CFB_TIMING && (perCnt + 4'h1 >= target);
      // saturation marks a signal too slow for the selected mode
      wire [31:0] refNext = (&refCnt) ? refCnt : refCnt + 32'h1;
      wire goHigh = !effHigh && refNext < CFB_UP_LIMIT; // [R26]
      wire goLow = effHigh && refNext > CFB_DN_LIMIT; // [R26]

      assign chanLevel[ch] = filtEnReg[ch] ? filtState : maskedIn[ch]; // [R02] [R14]
      assign highModeActive[ch] = effHigh;

      always_ff @(posedge clock)
      begin
        if (!rst_b)
        begin
          filtState <= 1'b0;
          filtCnt <= 20'h0;
          prevLevel <= 1'b0;
        end
        else if (clockEnable)
        begin
          filtCnt <= (filtDiff && !filtDone) ? filtCnt + 20'h1 : 20'h0;
          if (filtDone)
            filtState <= maskedIn[ch]; // [R14]
          prevLevel <= chanLevel[ch];
        end
      end

      always_ff @(posedge clock)
      begin
        if (!rst_b)
        begin
          countValue[ch] <= '0;
          ovfReg[ch] <= 1'b0;
        end
        else if (clockEnable)
        begin
          if (cntClear[ch])
            countValue[ch] <= '0; // [R09]
          else if (rise && !cntStop)
            countValue[ch] <= countValue[ch] + COUNT_W'(1);
          // a new overflow wins over a clear in the same cycle
          ovfReg[ch] <= (ovfReg[ch] && !ovfClear[ch])
                      || (rise && !cntStop && !cntClear[ch] && cntFull); // [R03]
        end
      end

      always_ff @(posedge clock)
      begin
        if (!rst_b)
        begin
          measState <= CFB_SYNC_WAIT;
          refCnt <= 32'h0;
          perCnt <= 4'h0;
          effHigh <= 1'b0;
          freqValue[ch] <= 32'h0;
        end
        else if (clockEnable)
        begin
          unique case (measState)
            CFB_SYNC_WAIT:
            begin
              refCnt <= 32'h0;
              perCnt <= 4'h0;
              if (rise)
                measState <= CFB_TIMING;
            end
            CFB_TIMING:
            begin
              if (periodEnd)
              begin
                freqValue[ch] <= refNext; // [R21] [R22]
                refCnt <= 32'h0;
                perCnt <= 4'h0;
              end
              else
              begin
                refCnt <= refNext;
                if (rise)
                  perCnt <= perCnt + 4'h1;
              end
            end
          endcase
          if (!autoReg[ch])
            effHigh <= highReg[ch]; // [R12]
          else if (periodEnd && (goHigh || goLow))
            effHigh <= goHigh; // [R11] [R26]
        end
      end
    end
  endgenerate

  // ****************************************************************
  // host watchdog, reset flag, activity indicator
  // ****************************************************************
  logic [$clog2(WD_STEP_CYCLES)-1:0] wdStepCnt;
  logic [7:0] wdUnits;
  wire wdStepEnd = wdStepCnt == ($clog2(WD_STEP_CYCLES))'(WD_STEP_CYCLES - 1);
  wire wdArmed = hwdEn && hostWdTimeout != 8'h00 && !hwdFlag;
  wire wdExpire = wdArmed && wdStepEnd && (wdUnits + 8'h1 == hostWdTimeout); // [R24]

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      wdStepCnt <= '0;
      wdUnits <= 8'h0;
      hwdFlag <= 1'b0;
    end
    else if (clockEnable)
    begin
      if (hostActivity || !wdArmed)
      begin
        wdStepCnt <= '0;
        wdUnits <= 8'h0;
      end
      else if (wdStepEnd)
      begin
        wdStepCnt <= '0;
        wdUnits <= wdUnits + 8'h1;
      end
      else
        wdStepCnt <= wdStepCnt + 1'b1;
      // expiry wins over a clear written in the same cycle
      hwdFlag <= (hwdFlag && !(wrOne && isHwdFlag)) || (wdExpire && !hostActivity); // [R07] [R18]
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      resetFlag <= 1'b1; // [R19]
      activityLed <= 1'b1;
    end
    else if (clockEnable)
    begin
      resetFlag <= (resetFlag && !rstFlagRead) || moduleWdReset; // [R08] [R19]
      if (cmdReceived)
        activityLed <= 1'b0; // [R20]
      else if (respSent)
        activityLed <= 1'b1; // [R20]
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence cmdSeen;
    clockEnable && cmdReceived;
  endsequence
  sequence ledStaysOff;
    !activityLed [*2];
  endsequence

  masked_read_a: assert property (rdStb && coilReq.addr == CFB_MASKED_IN && clockEnable // [R01]
    |=> coilRsp.valid && coilRsp.data == $past(chanSync[0] ^ invReg[0]))
    else $error("masked input status read wrong");
  filt_bypass_a: assert property (!filtEnReg[0] |-> chanLevel[0] == maskedIn[0]) // [R14]
    else $error("filter bypass not transparent");
  ovf_sticky_a: assert property (ovfReg[0] && clockEnable && !ovfClear[0] |=> ovfReg[0]) // [R03]
    else $error("overflow flag lost without clear");
  proto_lock_a: assert property (protoWrite && !overrideMode && clockEnable // [R17]
    |=> $stable(protoSel) ##1 $stable(protocolRtu))
    else $error("protocol changed outside override");
  wd_cause_a: assert property ($rose(hwdFlag) |-> $past(hwdEn) && $past(wdStepEnd)) // [R07]
    else $error("watchdog flag set without expiry");
  rst_clear_a: assert property (rstFlagRead && !moduleWdReset && clockEnable // [R19]
    |=> !resetFlag)
    else $error("reset flag not cleared after query");
  cnt_clear_a: assert property (cntClear[0] && clockEnable |=> countValue[0] == '0) // [R09]
    else $error("counter not cleared");
  halt_hold_a: assert property (haltReg[0] && ovfReg[0] && !cntClear[0] // [R13]
    |=> $stable(countValue[0]))
    else $error("counter moved after overflow halt");
  zero_write_a: assert property (wrStb && !coilReq.data && isHwdFlag && hwdFlag // [R25]
    |=> hwdFlag)
    else $error("zero write cleared a flag");
  led_off_a: assert property (cmdSeen ##1 (!respSent || !clockEnable) |-> ledStaysOff) // [R20]
    else $error("indicator not off after command");

endmodule : cfb_counter_bank

/* File: verification/cfb_host_model.sv */
/*
  remote host model: issues single-bit coil reads and writes on the coil port.
  assumes the bank answers on coilRsp at the same edge that takes a request.
*/
`timescale 1ns/100ps
module cfb_host_model
  import cfb_pkg::*;
(
  input wire logic clock,
  input wire cfb_coil_rsp_t coilRsp,
  output cfb_coil_req_t coilReq
);
  // ****************************************
  // coil access
  // ****************************************
  initial coilReq = '{valid: 1'b0, write: 1'b0, addr: 16'hFFFF, data: 1'b0};

  // released fields show the inverse so a stale sample cannot pass for a live one
  task automatic coil_access(input logic wr, input logic [15:0] a, input logic d,
                             output cfb_coil_rsp_t rsp);
    @(negedge clock);
    coilReq = '{valid: 1'b1, write: wr, addr: a, data: d};
    // the answer stands for one cycle only, so it is taken before the next edge
    @(negedge clock);
    rsp = coilRsp;
    coilReq = '{valid: 1'b0, write: ~wr, addr: ~a, data: ~d};
  endtask : coil_access
endmodule : cfb_host_model

/* File: verification/testbench.sv */
/*
  self-checking bench for the counter and frequency bank, reset flag reads first, then coil rows, then hand cases.
  assumes a small counter width and a short watchdog step to keep the run brief.
*/
`timescale 1ns/100ps
module testbench
  import cfb_pkg::*;
;
  typedef struct packed {logic [15:0] addr; logic exp; logic hit;} cfb_row_t;
  logic clock;
  logic rst_b;
  logic clockEnable;
  logic [CFB_CH-1:0] chanIn;
  logic configOverridePin;
  cfb_coil_req_t coilReq;
  cfb_coil_rsp_t coilRsp;
  cfb_coil_rsp_t rsp;
  logic [2:0][14:0] filterTimeUs;
  logic [7:0] hostWdTimeout;
  logic hostActivity;
  logic moduleWdReset;
  logic resetStatusQuery;
  logic cmdReceived;
  logic respSent;
  logic linkCfgReq;
  logic linkCfgAccept;
  logic overrideMode;
  logic protocolRtu;
  logic floatFormat;
  logic safeState;
  logic activityLed;
  logic resetFlag;
  logic [CFB_CH-1:0] retainEnable;
  logic [CFB_CH-1:0] highModeActive;
  logic [CFB_CH-1:0] overflowFlag;
  logic [CFB_CH-1:0][3:0] countValue;
  logic [CFB_CH-1:0][31:0] freqValue;
  cfb_row_t rows [15];
  int badCount = 0;
  int samplesChecked = 0;

  cfb_counter_bank #(.COUNT_W(4), .WD_STEP_CYCLES(10)) DUT (
    .clock(clock), .rst_b(rst_b), .clockEnable(clockEnable), .chanIn(chanIn),
    .configOverridePin(configOverridePin), .coilReq(coilReq), .coilRsp(coilRsp),
    .filterTimeUs(filterTimeUs), .hostWdTimeout(hostWdTimeout), .hostActivity(hostActivity),
    .moduleWdReset(moduleWdReset), .resetStatusQuery(resetStatusQuery),
    .cmdReceived(cmdReceived), .respSent(respSent), .linkCfgReq(linkCfgReq),
    .linkCfgAccept(linkCfgAccept), .overrideMode(overrideMode), .protocolRtu(protocolRtu),
    .floatFormat(floatFormat), .safeState(safeState), .activityLed(activityLed),
    .resetFlag(resetFlag), .retainEnable(retainEnable), .highModeActive(highModeActive),
    .overflowFlag(overflowFlag), .countValue(countValue), .freqValue(freqValue)
  );

  cfb_host_model host (.clock(clock), .coilRsp(coilRsp), .coilReq(coilReq));

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    samplesChecked++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
      badCount++;
    end
  endtask : check

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask : idle

  task automatic wr(input logic [15:0] a, input logic d);
    host.coil_access(1'b1, a, d, rsp);
  endtask : wr

  task automatic rd(input logic [15:0] a);
    host.coil_access(1'b0, a, 1'b0, rsp);
  endtask : rd

  task automatic strobe(ref logic s);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
  endtask : strobe

  task automatic pulses(input int ch, input int n, input int half);
    repeat (n)
    begin
      chanIn[ch] = 1'b1;
      idle(half);
      chanIn[ch] = 1'b0;
      idle(half);
    end
  endtask : pulses

  task automatic do_reset();
    rst_b = 1'b0;
    idle(16);
    rst_b = 1'b1;
    idle(4);
  endtask : do_reset

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // hang guard: the whole sequence needs well under 4000 cycles
  initial
  begin
    #(200_000);
    badCount++;
    finish_test();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    rst_b = 1'b0;
    clockEnable = 1'b1;
    chanIn = 8'h00;
    configOverridePin = 1'b0;
    filterTimeUs = '0;
    hostWdTimeout = 8'h00;
    hostActivity = 1'b0;
    moduleWdReset = 1'b0;
    resetStatusQuery = 1'b0;
    cmdReceived = 1'b0;
    respSent = 1'b0;
    linkCfgReq = 1'b0;
    rows = '{
      '{CFB_MASKED_IN, 1'b0, 1'b1},
      '{CFB_FILT_IN, 1'b0, 1'b1},
      '{CFB_OVF, 1'b0, 1'b1},
      '{CFB_PROTO, 1'b0, 1'b1},
      '{CFB_HWD_EN, 1'b1, 1'b1},
      '{CFB_FMT, 1'b1, 1'b1},
      '{CFB_HWD_FLAG, 1'b0, 1'b1},
      '{CFB_CLR + 16'h0007, 1'b0, 1'b1},
      '{CFB_RETAIN + 16'h0003, 1'b1, 1'b1},
      '{CFB_AUTO + 16'h0001, 1'b1, 1'b1},
      '{CFB_HIGH + 16'h0002, 1'b1, 1'b1},
      '{CFB_HALT + 16'h0004, 1'b1, 1'b1},
      '{CFB_FILT_EN + 16'h0005, 1'b1, 1'b1},
      '{CFB_INV + 16'h0006, 1'b1, 1'b1},
      '{16'h0500, 1'b0, 1'b0}};
    do_reset();
    check("reset flag out", 32'h1, 32'(resetFlag));
    check("led at reset", 32'h1, 32'(activityLed));
    rd(CFB_RST_FLAG);
    check("first reset read", 32'h7, 32'(rsp));
    rd(CFB_RST_FLAG);
    check("second reset read", 32'h6, 32'(rsp));
    foreach (rows[i])
    begin
      rd(rows[i].addr);
      check("row reset", 32'({2'b11 & {1'b1, rows[i].hit}, 1'b0}), 32'(rsp));
      wr(rows[i].addr, 1'b1);
      rd(rows[i].addr);
      check("row after one", 32'({1'b1, rows[i].hit, rows[i].exp}), 32'(rsp));
      wr(rows[i].addr, 1'b0);
      rd(rows[i].addr);
      check("row after zero", 32'({1'b1, rows[i].hit, 1'b0}), 32'(rsp));
    end
    strobe(moduleWdReset);
    check("reset flag wd", 32'h1, 32'(resetFlag));
    strobe(resetStatusQuery);
    check("reset flag query", 32'h0, 32'(resetFlag));
    strobe(cmdReceived);
    check("led on command", 32'h0, 32'(activityLed));
    strobe(respSent);
    check("led on response", 32'h1, 32'(activityLed));
    strobe(linkCfgReq);
    check("link cfg normal", 32'h0, 32'(linkCfgAccept));
    wr(CFB_FMT, 1'b1);
    check("format out", 32'h1, 32'(floatFormat));
    wr(CFB_RETAIN + 16'h0003, 1'b1);
    check("retain out", 32'h8, 32'(retainEnable));
    chanIn = 8'h05;
    wr(CFB_INV, 1'b1);
    rd(CFB_MASKED_IN);
    check("masked ch0", 32'h0, 32'(rsp.data));
    rd(CFB_MASKED_IN + 16'h0002);
    check("masked ch2", 32'h1, 32'(rsp.data));
    rd(CFB_FILT_IN + 16'h0002);
    check("filtered bypass", 32'h1, 32'(rsp.data));
    filterTimeUs[1] = 15'h0001;
    wr(CFB_FILT_EN + 16'h0002, 1'b1);
    chanIn[2] = 1'b0;
    idle(5);
    rd(CFB_FILT_IN + 16'h0002);
    check("filter holds", 32'h1, 32'(rsp.data));
    idle(30);
    rd(CFB_FILT_IN + 16'h0002);
    check("filter passes", 32'h0, 32'(rsp.data));
    chanIn[0] = 1'b0;
    wr(CFB_INV, 1'b0);
    wr(CFB_CLR, 1'b1);
    check("count cleared", 32'h0, 32'(countValue[0]));
    pulses(0, 3, 2);
    wr(CFB_CLR, 1'b0);
    idle(6);
    check("count three", 32'h3, 32'(countValue[0]));
    clockEnable = 1'b0;
    pulses(0, 2, 2);
    clockEnable = 1'b1;
    idle(6);
    check("count frozen", 32'h3, 32'(countValue[0]));
    pulses(0, 13, 2);
    idle(6);
    check("count wrapped", 32'h0, 32'(countValue[0]));
    check("overflow set", 32'h1, 32'(overflowFlag[0]));
    wr(CFB_OVF, 1'b0);
    rd(CFB_OVF);
    check("overflow kept", 32'h1, 32'(rsp.data));
    wr(CFB_OVF, 1'b1);
    check("overflow cleared", 32'h0, 32'(overflowFlag[0]));
    wr(CFB_HALT, 1'b1);
    pulses(0, 18, 2);
    idle(6);
    check("count halted", 32'h0, 32'(countValue[0]));
    pulses(1, 4, 10);
    idle(6);
    check("low mode period", 32'h14, freqValue[1]);
    wr(CFB_HIGH + 16'h0001, 1'b1);
    pulses(1, 24, 10);
    idle(6);
    check("high mode active", 32'h1, 32'(highModeActive[1]));
    check("high mode periods", 32'hDC, freqValue[1]);
    wr(CFB_AUTO + 16'h0003, 1'b1);
    pulses(3, 2, 10);
    idle(6);
    check("auto low period", 32'h14, freqValue[3]);
    check("auto goes high", 32'h1, 32'(highModeActive[3]));
    hostWdTimeout = 8'h02;
    wr(CFB_HWD_EN, 1'b1);
    idle(15);
    check("wd before kick", 32'h0, 32'(safeState));
    strobe(hostActivity);
    idle(15);
    check("wd after kick", 32'h0, 32'(safeState));
    idle(10);
    check("wd expired", 32'h1, 32'(safeState));
    wr(CFB_HWD_FLAG, 1'b0);
    rd(CFB_HWD_FLAG);
    check("wd flag kept", 32'h1, 32'(rsp.data));
    hostWdTimeout = 8'h00;
    wr(CFB_HWD_EN, 1'b0);
    wr(CFB_HWD_FLAG, 1'b1);
    check("wd flag cleared", 32'h0, 32'(safeState));
    configOverridePin = 1'b1;
    do_reset();
    check("override mode", 32'h1, 32'(overrideMode));
    check("reset flag again", 32'h1, 32'(resetFlag));
    wr(CFB_PROTO, 1'b1);
    rd(CFB_PROTO);
    check("proto in override", 32'h1, 32'(rsp.data));
    check("proto forced", 32'h0, 32'(protocolRtu));
    strobe(linkCfgReq);
    check("link cfg override", 32'h1, 32'(linkCfgAccept));
    finish_test();
  end
endmodule : testbench
